//--- lsc_pkg.sv
// Constants, types and helpers shared by the low-speed power control block
//--------------------------------------------------------------------------
// Summary of operation
// - Select bit b0 at 1 enters low-speed mode; 0 returns to main mode field.
// - Transition flag b4 rises on each select rewrite, falls when change completes.
// - Writes to the low-speed register are ignored while the flag is 1.
// - Writes are blocked from sleep entry until sleep is exited.
// - Writes are blocked while flash program or erase runs.
// - Main power mode register is locked while low-speed select is 1.
// - Select cannot be set while PLL or any other oscillator runs.
// - Reset leaves high-speed mode with the select bit clear.
// - Return source codes: 000 slow, 001 fast, 010 main; others refused.
// - Enable b7 gates the return switch; disabled exit keeps clock source.
// - Switching exit starts the oscillator the selected source needs.
// - Switching exit copies return select into system clock source select.
// - Switching exit clears the low-speed select bit.
// - Switching exit leaves clock divider settings untouched.
// - Reserved bits read 0; software writes 0.
// - Main mode field: 000 high-speed, 010 middle-speed, others refused.
//--------------------------------------------------------------------------
package lsc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [19:0] LSC_IDX_MAIN = 20'h800A0;
  localparam logic [19:0] LSC_IDX_RET = 20'h800A1;
  localparam logic [19:0] LSC_IDX_LSPC = 20'h800AA;
  localparam logic [19:0] LSC_IDX_OSC = 20'h800B0;
  localparam logic [19:0] LSC_IDX_CLK = 20'h800B1;
  localparam logic [19:0] LSC_IDX_WP = 20'h800B2;

  // Field positions
  localparam int LSC_LS_SEL_BIT = 0;
  localparam int LSC_TSF_BIT = 4;
  localparam int LSC_RET_EN_BIT = 7;
  localparam int LSC_UNLOCK_BIT = 1;

  // Mode and source encodings
  localparam logic [2:0] LSC_MODE_HIGH = 3'h0;
  localparam logic [2:0] LSC_MODE_MID = 3'h2;
  localparam logic [2:0] LSC_SRC_SLOW = 3'h0;
  localparam logic [2:0] LSC_SRC_FAST = 3'h1;
  localparam logic [2:0] LSC_SRC_MAIN = 3'h2;

  // Settling time of a power mode change
  localparam int LSC_CLK_MHZ = 100;
  localparam int LSC_SETTLE_NS = 1000;
  localparam int LSC_CNT_W = 8;
  localparam logic [LSC_CNT_W-1:0] LSC_SETTLE_CYC =
    LSC_CNT_W'((LSC_SETTLE_NS * LSC_CLK_MHZ + 999) / 1000);
  localparam logic [LSC_CNT_W-1:0] LSC_CNT_ZERO = 8'h00;

  // Oscillator stop controls, 1 means stopped
  typedef struct packed {
    logic slow_internal_osc_stop;
    logic main_osc_stop;
    logic fast_internal_osc_stop;
    logic pll_stop_ctrl;
  } lsc_osc_s;

  localparam lsc_osc_s LSC_OSC_RESET = 4'h7;

  // Sleep tracking states
  typedef enum logic [1:0] {
    LSC_ST_RUN = 2'b01,
    LSC_ST_SLEEP = 2'b10
  } lsc_state_e;

  // Legal return clock source code
  function automatic logic lsc_src_valid(input logic [2:0] code);
    lsc_src_valid = (code == LSC_SRC_SLOW) || (code == LSC_SRC_FAST) ||
                    (code == LSC_SRC_MAIN);
  endfunction : lsc_src_valid

  // Byte address of a register index
  function automatic logic [31:0] lsc_addr(input logic [19:0] idx);
    lsc_addr = {10'h000, idx, 2'b00};
  endfunction : lsc_addr

endpackage : lsc_pkg

//--- lsc_settle_timer.sv
// Settling counter behind a power mode transition flag
`timescale 1ns/1ps
module lsc_settle_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Start of a mode change, and the resulting flag
  input wire logic start,
  output logic busy
);

  logic [lsc_pkg::LSC_CNT_W-1:0] cnt_q;

  // A new start reloads even while counting, so the flag never drops early
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= lsc_pkg::LSC_CNT_ZERO;
    else if (start)
      cnt_q <= lsc_pkg::LSC_SETTLE_CYC;
    else if (busy)
      cnt_q <= cnt_q - 8'h01;
  end

  // Flag straight from the counter register
  assign busy = (cnt_q != lsc_pkg::LSC_CNT_ZERO);

endmodule : lsc_settle_timer

//--- lsc_wake_switch.sv
// Oscillator and source settings applied at a switching sleep exit
`timescale 1ns/1ps
module lsc_wake_switch (
  // Return selection
  input wire logic [2:0] ret_sel,
  // Present and next oscillator controls
  input wire lsc_pkg::lsc_osc_s osc_now,
  output lsc_pkg::lsc_osc_s osc_wake,
  output logic sel_ok
);

  // Only documented codes may switch; others leave everything alone
  assign sel_ok = lsc_pkg::lsc_src_valid(ret_sel);

  // Start the selected oscillator, others keep their state; PLL untouched
  assign osc_wake.pll_stop_ctrl = osc_now.pll_stop_ctrl;
  assign osc_wake.slow_internal_osc_stop = (ret_sel == lsc_pkg::LSC_SRC_SLOW) ?
    1'b0 : osc_now.slow_internal_osc_stop;
  assign osc_wake.fast_internal_osc_stop = (ret_sel == lsc_pkg::LSC_SRC_FAST) ?
    1'b0 : osc_now.fast_internal_osc_stop;
  assign osc_wake.main_osc_stop = (ret_sel == lsc_pkg::LSC_SRC_MAIN) ?
    1'b0 : osc_now.main_osc_stop;

endmodule : lsc_wake_switch

//--- lsc_top.sv
// Low-speed power mode control and sleep-return clock switch, APB slave
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module lsc_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // System events
  input wire logic sleep_entry,
  input wire logic sleep_exit,
  input wire logic flash_pe_busy,
  // Clock system controls
  output logic low_speed_mode,
  output logic [2:0] main_power_mode_field,
  output lsc_pkg::lsc_osc_s osc_stop,
  output logic [2:0] system_clock_source_select
);

  //------------------------------------------------------------------
  // Declarations
  //------------------------------------------------------------------
  logic ls_q;
  logic ls_d;
  logic [2:0] mode_q;
  logic [2:0] ret_sel_q;
  logic ret_en_q;
  lsc_pkg::lsc_osc_s osc_q;
  lsc_pkg::lsc_osc_s osc_d;
  lsc_pkg::lsc_osc_s osc_wake;
  logic [2:0] clk_sel_q;
  logic unlock_q;
  logic [31:0] prdata_q;
  lsc_pkg::lsc_state_e state_q;
  lsc_pkg::lsc_state_e state_d;
  logic wr_en;
  logic rd_setup;
  logic hit_main;
  logic hit_ret;
  logic hit_lspc;
  logic hit_osc;
  logic hit_clk;
  logic hit_wp;
  logic hit_any;
  logic sleep_block;
  logic ls_busy;
  logic mm_busy;
  logic osc_running;
  logic ls_wr_ok;
  logic ls_take;
  logic ls_start;
  logic mm_take;
  logic wake_ok;
  logic wake_sw;
  logic [7:0] rd_lspc;
  logic [7:0] rd_main;
  logic [7:0] rd_ret;
  logic [7:0] rd_byte;

  //------------------------------------------------------------------
  // Bus decode
  //------------------------------------------------------------------
  // Zero wait states: every access phase completes at once
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit_main = (paddr == lsc_pkg::lsc_addr(lsc_pkg::LSC_IDX_MAIN));
  assign hit_ret = (paddr == lsc_pkg::lsc_addr(lsc_pkg::LSC_IDX_RET));
  assign hit_lspc = (paddr == lsc_pkg::lsc_addr(lsc_pkg::LSC_IDX_LSPC));
  assign hit_osc = (paddr == lsc_pkg::lsc_addr(lsc_pkg::LSC_IDX_OSC));
  assign hit_clk = (paddr == lsc_pkg::lsc_addr(lsc_pkg::LSC_IDX_CLK));
  assign hit_wp = (paddr == lsc_pkg::lsc_addr(lsc_pkg::LSC_IDX_WP));
  assign hit_any = hit_main | hit_ret | hit_lspc | hit_osc | hit_clk | hit_wp;
  // Unmapped addresses answer with an error, writes are dropped
  assign pslverr = psel & penable & ~hit_any;

  //------------------------------------------------------------------
  // Sleep tracking
  //------------------------------------------------------------------
  // Entry pulse itself already blocks, so a write in that cycle is lost
  assign sleep_block = (state_q == lsc_pkg::LSC_ST_SLEEP) | sleep_entry;

  // Next sleep state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      lsc_pkg::LSC_ST_RUN:
        if (sleep_entry)
          state_d = lsc_pkg::LSC_ST_SLEEP;
      lsc_pkg::LSC_ST_SLEEP:
        if (sleep_exit)
          state_d = lsc_pkg::LSC_ST_RUN;
      default:
        state_d = lsc_pkg::LSC_ST_RUN;
    endcase
  end

  // Sleep state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= lsc_pkg::LSC_ST_RUN;
    else
      state_q <= state_d;
  end

  //------------------------------------------------------------------
  // Low-speed select
  //------------------------------------------------------------------
  // Any oscillator other than the sub-clock still running
  assign osc_running = ~osc_q.pll_stop_ctrl | ~osc_q.fast_internal_osc_stop |
                       ~osc_q.main_osc_stop | ~osc_q.slow_internal_osc_stop;
  // Unlock, settle flag, sleep and flash all gate the write
  assign ls_wr_ok = wr_en & hit_lspc & unlock_q & ~ls_busy & ~sleep_block &
                    ~flash_pe_busy;
  // Entry refused while an oscillator runs; the write then is a no-op
  assign ls_take = ls_wr_ok &
                   ~(pwdata[lsc_pkg::LSC_LS_SEL_BIT] & osc_running);
  // Switching exit needs a legal code and a real sleep period
  assign wake_sw = sleep_exit & (state_q == lsc_pkg::LSC_ST_SLEEP) &
                   ret_en_q & wake_ok;
  // Wake has priority over a same-cycle write, which sleep blocks anyway
  assign ls_d = wake_sw ? 1'b0 :
                ls_take ? pwdata[lsc_pkg::LSC_LS_SEL_BIT] : ls_q;
  // Every accepted rewrite starts a transition, as does a wake clear
  assign ls_start = ls_take | (wake_sw & ls_q);

  // Select register; reset lands in high-speed mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ls_q <= 1'b0;
    else
      ls_q <= ls_d;
  end

  // Low-speed transition flag
  lsc_settle_timer u_ls_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(ls_start),
    .busy(ls_busy)
  );

  //------------------------------------------------------------------
  // Main power mode
  //------------------------------------------------------------------
  // Locked in low-speed mode; prohibited codes are ignored
  assign mm_take = wr_en & hit_main & unlock_q & ~mm_busy & ~sleep_block &
                   ~flash_pe_busy & ~ls_q &
                   ((pwdata[2:0] == lsc_pkg::LSC_MODE_HIGH) |
                    (pwdata[2:0] == lsc_pkg::LSC_MODE_MID));

  // Mode field register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= lsc_pkg::LSC_MODE_HIGH;
    else if (mm_take)
      mode_q <= pwdata[2:0];
  end

  // Main mode transition flag
  lsc_settle_timer u_mm_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(mm_take),
    .busy(mm_busy)
  );

  //------------------------------------------------------------------
  // Sleep-return clock switch
  //------------------------------------------------------------------
  lsc_wake_switch u_wake (
    .ret_sel(ret_sel_q),
    .osc_now(osc_q),
    .osc_wake(osc_wake),
    .sel_ok(wake_ok)
  );

  // Return control register; only the select field and enable are stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ret_sel_q <= lsc_pkg::LSC_SRC_SLOW;
      ret_en_q <= 1'b0;
    end
    else if (wr_en & hit_ret & unlock_q)
    begin
      ret_sel_q <= pwdata[2:0];
      ret_en_q <= pwdata[lsc_pkg::LSC_RET_EN_BIT];
    end
  end

  // Oscillator controls: wake overrides software in the same cycle
  assign osc_d = wake_sw ? osc_wake :
                 (wr_en & hit_osc & unlock_q) ? lsc_pkg::lsc_osc_s'(pwdata[3:0]) :
                 osc_q;

  // Oscillator stop register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_q <= lsc_pkg::LSC_OSC_RESET;
    else
      osc_q <= osc_d;
  end

  // System clock source; dividers live elsewhere and are never touched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_sel_q <= lsc_pkg::LSC_SRC_SLOW;
    else if (wake_sw)
      clk_sel_q <= ret_sel_q;
    else if (wr_en & hit_clk & unlock_q)
      clk_sel_q <= pwdata[2:0];
  end

  // Write protection unlock; always writable by design
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      unlock_q <= 1'b0;
    else if (wr_en & hit_wp)
      unlock_q <= pwdata[lsc_pkg::LSC_UNLOCK_BIT];
  end

  //------------------------------------------------------------------
  // Read back
  //------------------------------------------------------------------
  // Reserved bits read as zero
  assign rd_lspc = (8'(ls_q) << lsc_pkg::LSC_LS_SEL_BIT) |
                   (8'(ls_busy) << lsc_pkg::LSC_TSF_BIT);
  assign rd_main = {3'h0, mm_busy, 1'b0, mode_q};
  assign rd_ret = (8'(ret_en_q) << lsc_pkg::LSC_RET_EN_BIT) | {5'h00, ret_sel_q};
  assign rd_byte = hit_lspc ? rd_lspc :
                   hit_main ? rd_main :
                   hit_ret ? rd_ret :
                   hit_osc ? {4'h0, osc_q} :
                   hit_clk ? {5'h00, clk_sel_q} :
                   hit_wp ? (8'(unlock_q) << lsc_pkg::LSC_UNLOCK_BIT) : 8'h00;

  // Read data captured in the setup cycle, stable through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (rd_setup)
      prdata_q <= {24'h00_0000, rd_byte};
  end

  //------------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------------
  assign prdata = prdata_q;
  assign low_speed_mode = ls_q;
  assign main_power_mode_field = mode_q;
  assign osc_stop = osc_q;
  assign system_clock_source_select = clk_sel_q;

  //------------------------------------------------------------------
  // Checks
  //------------------------------------------------------------------
  chk_ls_enter: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_take & ~wake_sw) |=> (ls_q == $past(pwdata[lsc_pkg::LSC_LS_SEL_BIT])))
    else $error("low-speed select did not follow accepted write");

  chk_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ls_start |=> ls_busy [*8])
    else $error("transition flag dropped too early");

  chk_busy_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_busy & wr_en & hit_lspc & ~wake_sw) |=> $stable(ls_q))
    else $error("select changed while in transition");

  chk_sleep_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_block & wr_en & hit_lspc & ~wake_sw) |=> $stable(ls_q))
    else $error("select written during sleep");

  chk_flash_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (flash_pe_busy & wr_en & hit_lspc & ~wake_sw) |-> !ls_start ##1 $stable(ls_q))
    else $error("select changed during flash operation");

  chk_main_lock: assert property (@(posedge pclk) disable iff (!presetn)
    ls_q |=> $stable(mode_q))
    else $error("main mode changed in low-speed mode");

  chk_osc_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    (~ls_q & osc_running) |=> ~ls_q)
    else $error("low-speed entered with oscillator running");

  chk_wake_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wake_sw |=> ~ls_q ##0 (system_clock_source_select == $past(ret_sel_q)))
    else $error("switching exit did not clear select or copy source");

  chk_wake_none: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_exit & ~ret_en_q & ~(wr_en & hit_clk)) |=> $stable(clk_sel_q))
    else $error("clock source changed with switching disabled");

  chk_unlock_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en & hit_main & ~unlock_q) |=> $stable(mode_q))
    else $error("main mode written while write protection was on");

  chk_reset_state: assert property (@(posedge pclk)
    $rose(presetn) |-> ~ls_q && (mode_q == lsc_pkg::LSC_MODE_HIGH))
    else $error("block did not start in high-speed mode");

  chk_wake_slow: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_sw & (ret_sel_q == lsc_pkg::LSC_SRC_SLOW)) |=> ~osc_q.slow_internal_osc_stop)
    else $error("slow internal oscillator not started at wake");

  chk_wake_fast: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_sw & (ret_sel_q == lsc_pkg::LSC_SRC_FAST)) |=> ~osc_q.fast_internal_osc_stop)
    else $error("fast internal oscillator not started at wake");

  chk_wake_main: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_sw & (ret_sel_q == lsc_pkg::LSC_SRC_MAIN)) |=> ~osc_q.main_osc_stop)
    else $error("main oscillator not started at wake");

  chk_wake_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_exit & (state_q == lsc_pkg::LSC_ST_SLEEP) & ret_en_q &
     (ret_sel_q > lsc_pkg::LSC_SRC_MAIN) & ~(wr_en & hit_clk)) |=> $stable(clk_sel_q))
    else $error("illegal return code switched the clock source");

  chk_wake_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_sw & ls_q) |=> ls_busy)
    else $error("wake clear of select raised no transition flag");

  chk_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup & hit_lspc) |=> (prdata[31:5] == 27'h0) && (prdata[3:1] == 3'h0))
    else $error("reserved bits of low-speed register read nonzero");

  chk_mode_legal: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == lsc_pkg::LSC_MODE_HIGH) || (mode_q == lsc_pkg::LSC_MODE_MID))
    else $error("main mode field holds a prohibited code");

endmodule : lsc_top

//--- lsc_tb.sv
// Self-checking bench for the low-speed power control block
`timescale 1ns/1ps
module tb;
  //------------------------------------------------------------------
  // Signals and constants
  //------------------------------------------------------------------
  localparam logic [31:0] A_MAIN = 32'h00200280;
  localparam logic [31:0] A_RET = 32'h00200284;
  localparam logic [31:0] A_LSPC = 32'h002002A8;
  localparam logic [31:0] A_OSC = 32'h002002C0;
  localparam logic [31:0] A_CLK = 32'h002002C4;
  localparam logic [31:0] A_WP = 32'h002002C8;
  localparam logic [31:0] A_NONE = 32'h00200300;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic sleep_entry = 1'b0;
  logic sleep_exit = 1'b0;
  logic flash_pe_busy = 1'b0;
  logic low_speed_mode;
  logic [2:0] main_power_mode_field;
  lsc_pkg::lsc_osc_s osc_stop;
  logic [2:0] system_clock_source_select;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] rdat;
  logic rerr;
  logic [3:0] exo [4] = '{4'h7, 4'hD, 4'hB, 4'hF};
  logic [2:0] exs [4] = '{3'h0, 3'h1, 3'h2, 3'h2};

  lsc_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sleep_entry(sleep_entry), .sleep_exit(sleep_exit), .flash_pe_busy(flash_pe_busy),
    .low_speed_mode(low_speed_mode), .main_power_mode_field(main_power_mode_field),
    .osc_stop(osc_stop), .system_clock_source_select(system_clock_source_select)
  );

  // Free-running clock, 10 ns period
  initial
  begin
    forever #5 pclk = ~pclk;
  end

  //------------------------------------------------------------------
  // Tasks
  //------------------------------------------------------------------
  // Counts and reports one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  // One APB transfer; an idle cycle follows so psel never toggles twice in a step
  // Waits on pready alone; only the watchdog ends a hang
  task automatic apb(input logic [31:0] a, input logic wr, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 8'h00);
    chk(rdat, exp);
  endtask : rd_chk

  // Single-cycle event pulse on the sleep entry or exit input
  task automatic pulse(input logic ent);
    if (ent)
      sleep_entry <= 1'b1;
    else
      sleep_exit <= 1'b1;
    @(posedge pclk);
    sleep_entry <= 1'b0;
    sleep_exit <= 1'b0;
    @(posedge pclk);
  endtask : pulse

  // Settling of a mode change is 100 cycles; margin added
  task automatic settle();
    repeat (110) @(posedge pclk);
  endtask : settle

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Watchdog well beyond the roughly 610 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    conclude();
  end

  //------------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, low_speed_mode}, 32'h0);
    chk({29'h0, main_power_mode_field}, 32'h0);
    chk({31'h0, pready}, 32'h1);
    rd_chk(A_LSPC, 32'h0);
    // Locked writes are dropped
    apb(A_MAIN, 1'b1, 8'h02);
    chk({29'h0, main_power_mode_field}, 32'h0);
    apb(A_WP, 1'b1, 8'h02);
    // Reserved bits of the return register read zero
    apb(A_RET, 1'b1, 8'hFF);
    rd_chk(A_RET, 32'h87);
    chk({31'h0, rerr}, 32'h0);
    apb(A_RET, 1'b1, 8'h00);
    apb(A_NONE, 1'b0, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    // Main mode field codes and its own flag
    apb(A_MAIN, 1'b1, 8'h02);
    chk({29'h0, main_power_mode_field}, 32'h2);
    rd_chk(A_MAIN, 32'h12);
    settle();
    apb(A_MAIN, 1'b1, 8'h03);
    chk({29'h0, main_power_mode_field}, 32'h2);
    apb(A_MAIN, 1'b1, 8'h00);
    chk({29'h0, main_power_mode_field}, 32'h0);
    settle();
    // Entry refused while any one oscillator runs
    for (int i = 0; i < 4; i++)
    begin
      apb(A_OSC, 1'b1, 8'h0F & ~(8'h01 << i));
      apb(A_LSPC, 1'b1, 8'h01);
      rd_chk(A_LSPC, 32'h0);
    end
    // Flash program or erase blocks the register; raised only outside low-speed mode
    apb(A_OSC, 1'b1, 8'h0F);
    flash_pe_busy <= 1'b1;
    apb(A_LSPC, 1'b1, 8'h01);
    flash_pe_busy <= 1'b0;
    chk({31'h0, low_speed_mode}, 32'h0);
    rd_chk(A_LSPC, 32'h0);
    // Entry with all oscillators stopped
    apb(A_LSPC, 1'b1, 8'h01);
    chk({31'h0, low_speed_mode}, 32'h1);
    rd_chk(A_LSPC, 32'h11);
    apb(A_LSPC, 1'b1, 8'h00);
    chk({31'h0, low_speed_mode}, 32'h1);
    settle();
    rd_chk(A_LSPC, 32'h01);
    apb(A_MAIN, 1'b1, 8'h02);
    chk({29'h0, main_power_mode_field}, 32'h0);
    // Sleep blocks writes; switching exit leaves low-speed mode
    apb(A_RET, 1'b1, 8'h80);
    pulse(1'b1);
    apb(A_LSPC, 1'b1, 8'h00);
    rd_chk(A_LSPC, 32'h01);
    pulse(1'b0);
    chk({31'h0, low_speed_mode}, 32'h0);
    chk({28'h0, osc_stop}, 32'h7);
    rd_chk(A_LSPC, 32'h10);
    settle();
    // Every return source code, then an illegal one
    for (int c = 0; c < 4; c++)
    begin
      apb(A_OSC, 1'b1, 8'h0F);
      apb(A_RET, 1'b1, 8'h80 | c[7:0]);
      pulse(1'b1);
      pulse(1'b0);
      chk({29'h0, system_clock_source_select}, {29'h0, exs[c]});
      chk({28'h0, osc_stop}, {28'h0, exo[c]});
    end
    // Switching disabled keeps a source that software wrote directly
    apb(A_CLK, 1'b1, 8'h01);
    rd_chk(A_CLK, 32'h1);
    apb(A_RET, 1'b1, 8'h01);
    pulse(1'b1);
    pulse(1'b0);
    chk({29'h0, system_clock_source_select}, 32'h1);
    chk({28'h0, osc_stop}, 32'hF);
    rd_chk(A_CLK, 32'h1);
    conclude();
  end
endmodule : tb
